// ===== hw/simd_precision_expand_reduce.sv
// Purpose: packed byte/halfword expand and halfword/word reduce, one register stage
// Assumes: decoder hands over the instruction word with both source operands
// Notes:   result appears one cycle after the request; flags are never touched
//
// Operation
// - left pair: bytes 31..24 and 23..16
// - left alternate: bytes 31..24 and 15..8
// - right pair: bytes 15..8 and 7..0
// - right alternate: bytes 23..16 and 7..0
// - expand by eight zero bits above
// - expand decode: group, minor, fixed fields
// - reduce keeps low byte of halfwords
// - operand_a bytes go to upper lanes
// - arithmetic shift, keep low sixteen bits
// - rounding adds one at discarded bit
// - shift count is five unsigned bits
// - saturation flag field never written
// - shift reduce decode, bit 10 rounds
// - no data dependent exceptions
`timescale 1ns/10ps
module simd_precision_expand_reduce (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	// decoder request and access permission
	input  wire prec_pkg::prec_req_t   req,
	input  wire logic                  dsp_access_ok,
	// register file write-back
	output prec_pkg::prec_rsp_t        rsp,
	// saturation flag write strobe to control register
	output logic                       sat_flag_we
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire logic        major_hit;
	wire logic [6:0]  minor_hi;
	wire logic [6:0]  minor_lo;
	wire logic        exp_fixed;
	wire logic        red_fixed;
	wire logic [4:0]  shift_count;
	wire logic        rnd;
	prec_pkg::prec_op_t op;

	assign major_hit = req.instr[prec_pkg::MAJOR_MSB:prec_pkg::MAJOR_LSB] == prec_pkg::MAJOR_GROUP;
	assign minor_hi  = req.instr[15:9];
	assign minor_lo  = req.instr[9:3];
	assign exp_fixed = major_hit && req.instr[8:6] == prec_pkg::EXP_F86
		&& req.instr[5:3] == prec_pkg::EXP_F53 && req.instr[2:0] == prec_pkg::EXP_F20;
	assign red_fixed = major_hit && req.instr[2:0] == prec_pkg::RED_F20;
	assign shift_count = req.instr[prec_pkg::SA_MSB:prec_pkg::SA_LSB];
	assign rnd         = req.instr[prec_pkg::RND_BIT];

	// opcode select; expand minor codes sit in 15..9, reduce codes in 9..3
	always_comb begin
		op = prec_pkg::op_none;
		if (exp_fixed && minor_hi == prec_pkg::MIN_EXP_LP) begin
			op = prec_pkg::op_expand_u8_left_pair;
		end else if (exp_fixed && minor_hi == prec_pkg::MIN_EXP_LA) begin
			op = prec_pkg::op_expand_u8_left_alternate;
		end else if (exp_fixed && minor_hi == prec_pkg::MIN_EXP_RP) begin
			op = prec_pkg::op_expand_u8_right_pair;
		end else if (exp_fixed && minor_hi == prec_pkg::MIN_EXP_RA) begin
			op = prec_pkg::op_expand_u8_right_alternate;
		end else if (red_fixed && minor_lo == prec_pkg::MIN_RED_HB) begin
			op = prec_pkg::op_reduce_halfwords_to_bytes;
		end else if (red_fixed && minor_lo == prec_pkg::MIN_SHR) begin
			op = rnd ? prec_pkg::op_shift_round_reduce_words : prec_pkg::op_shift_reduce_words;
		end
	end

	// ------------------------------------------------------------
	// expand datapath
	// ------------------------------------------------------------
	wire logic [31:0] exp_lp;
	wire logic [31:0] exp_la;
	wire logic [31:0] exp_rp;
	wire logic [31:0] exp_ra;
	assign exp_lp = {prec_pkg::ZERO_BYTE, req.operand_a[31:24], prec_pkg::ZERO_BYTE, req.operand_a[23:16]};
	assign exp_la = {prec_pkg::ZERO_BYTE, req.operand_a[31:24], prec_pkg::ZERO_BYTE, req.operand_a[15:8]};
	assign exp_rp = {prec_pkg::ZERO_BYTE, req.operand_a[15:8], prec_pkg::ZERO_BYTE, req.operand_a[7:0]};
	assign exp_ra = {prec_pkg::ZERO_BYTE, req.operand_a[23:16], prec_pkg::ZERO_BYTE, req.operand_a[7:0]};

	// ------------------------------------------------------------
	// reduce datapath
	// ------------------------------------------------------------
	wire logic [31:0] red_hb;
	assign red_hb = {req.operand_a[23:16], req.operand_a[7:0], req.operand_b[23:16], req.operand_b[7:0]};

	// shift with one guard bit so rounding is a single 17-bit add
	wire logic signed [32:0] ext_a;
	wire logic signed [32:0] ext_b;
	wire logic [32:0]        sh_a;
	wire logic [32:0]        sh_b;
	wire logic [16:0]        rnd_a;
	wire logic [16:0]        rnd_b;
	wire logic               add_one;
	wire logic [31:0]        shr_plain;
	wire logic [31:0]        shr_round;
	assign ext_a = $signed({req.operand_a, 1'b0});
	assign ext_b = $signed({req.operand_b, 1'b0});
	assign sh_a  = ext_a >>> shift_count;
	assign sh_b  = ext_b >>> shift_count;
	assign add_one = shift_count != 5'h00;
	assign rnd_a = sh_a[16:0] + {16'h0000, add_one};
	assign rnd_b = sh_b[16:0] + {16'h0000, add_one};
	assign shr_plain = {sh_b[16:1], sh_a[16:1]};
	assign shr_round = {rnd_b[16:1], rnd_a[16:1]};

	// ------------------------------------------------------------
	// result select
	// ------------------------------------------------------------
	logic [31:0] result_nxt;
	wire logic   hit;
	assign hit = req.valid && op != prec_pkg::op_none;
	always_comb begin
		case (op)
			prec_pkg::op_expand_u8_left_pair:       result_nxt = exp_lp;
			prec_pkg::op_expand_u8_left_alternate:  result_nxt = exp_la;
			prec_pkg::op_expand_u8_right_pair:      result_nxt = exp_rp;
			prec_pkg::op_expand_u8_right_alternate: result_nxt = exp_ra;
			prec_pkg::op_reduce_halfwords_to_bytes: result_nxt = red_hb;
			prec_pkg::op_shift_reduce_words:        result_nxt = shr_plain;
			prec_pkg::op_shift_round_reduce_words:  result_nxt = shr_round;
			default:                                result_nxt = prec_pkg::RESET_WORD;
		endcase
	end

	// ------------------------------------------------------------
	// write-back stage
	// ------------------------------------------------------------
	prec_pkg::prec_rsp_t rsp_r;
	prec_pkg::prec_rsp_t rsp_nxt;
	always_comb begin
		rsp_nxt           = '0;
		rsp_nxt.write_en  = hit && dsp_access_ok;
		rsp_nxt.exception = hit && !dsp_access_ok;
		// reduce-to-bytes alone targets a third register
		rsp_nxt.dest_is_b = op != prec_pkg::op_reduce_halfwords_to_bytes;
		rsp_nxt.result    = (hit && dsp_access_ok) ? result_nxt : prec_pkg::RESET_WORD;
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign rsp = rsp_r;

	always_ff @(posedge core_clk) begin
		sat_flag_we <= 1'b0;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_expand_lp;
		@(posedge core_clk) disable iff (!rst_n)
		req.valid && dsp_access_ok && op == prec_pkg::op_expand_u8_left_pair
		|=> rsp.write_en && rsp.result == {8'h00, $past(req.operand_a[31:24]), 8'h00, $past(req.operand_a[23:16])};
	endproperty
	a_expand_lp: assert property (p_expand_lp) else $error("left pair expand wrong");

	property p_expand_la;
		@(posedge core_clk) disable iff (!rst_n)
		req.valid && dsp_access_ok && op == prec_pkg::op_expand_u8_left_alternate
		|=> rsp.result == {8'h00, $past(req.operand_a[31:24]), 8'h00, $past(req.operand_a[15:8])};
	endproperty
	a_expand_la: assert property (p_expand_la) else $error("left alternate expand wrong");

	property p_expand_rp;
		@(posedge core_clk) disable iff (!rst_n)
		req.valid && dsp_access_ok && op == prec_pkg::op_expand_u8_right_pair
		|=> rsp.result == {8'h00, $past(req.operand_a[15:8]), 8'h00, $past(req.operand_a[7:0])};
	endproperty
	a_expand_rp: assert property (p_expand_rp) else $error("right pair expand wrong");

	property p_expand_ra;
		@(posedge core_clk) disable iff (!rst_n)
		req.valid && dsp_access_ok && op == prec_pkg::op_expand_u8_right_alternate
		|=> rsp.result[31:24] == 8'h00 && rsp.result[15:8] == 8'h00
			&& rsp.result[23:16] == $past(req.operand_a[23:16])
			&& rsp.result[7:0] == $past(req.operand_a[7:0]);
	endproperty
	a_expand_ra: assert property (p_expand_ra) else $error("right alternate expand wrong");

	property p_reduce_lanes;
		@(posedge core_clk) disable iff (!rst_n)
		req.valid && dsp_access_ok && op == prec_pkg::op_reduce_halfwords_to_bytes
		|=> !rsp.dest_is_b && rsp.result[31:16] == {$past(req.operand_a[23:16]), $past(req.operand_a[7:0])}
			&& rsp.result[15:0] == {$past(req.operand_b[23:16]), $past(req.operand_b[7:0])};
	endproperty
	a_reduce_lanes: assert property (p_reduce_lanes) else $error("byte reduce lanes wrong");

	property p_shift_plain;
		@(posedge core_clk) disable iff (!rst_n)
		req.valid && dsp_access_ok && op == prec_pkg::op_shift_reduce_words
		|=> rsp.result[15:0] == 16'($signed($past(req.operand_a)) >>> $past(shift_count))
			&& rsp.result[31:16] == 16'($signed($past(req.operand_b)) >>> $past(shift_count));
	endproperty
	a_shift_plain: assert property (p_shift_plain) else $error("shift reduce wrong");

	property p_round_zero;
		@(posedge core_clk) disable iff (!rst_n)
		req.valid && dsp_access_ok && op == prec_pkg::op_shift_round_reduce_words && shift_count == 5'h00
		|=> rsp.result == {$past(req.operand_b[15:0]), $past(req.operand_a[15:0])};
	endproperty
	a_round_zero: assert property (p_round_zero) else $error("zero shift rounding altered value");

	property p_no_access;
		@(posedge core_clk) disable iff (!rst_n)
		hit && !dsp_access_ok |=> rsp.exception && !rsp.write_en && rsp.result == 32'h0000_0000;
	endproperty
	a_no_access: assert property (p_no_access) else $error("write not suppressed without access");

	property p_no_flag;
		@(posedge core_clk) disable iff (!rst_n)
		hit |=> !sat_flag_we [*2];
	endproperty
	a_no_flag: assert property (p_no_flag) else $error("saturation flag written");

	property p_exc_cause;
		@(posedge core_clk) disable iff (!rst_n)
		rsp.exception |-> $past(hit) && !$past(dsp_access_ok);
	endproperty
	a_exc_cause: assert property (p_exc_cause) else $error("exception without permission fault");
endmodule

// ===== hw/prec_pkg.sv
// Purpose: shared constants and types for the precision expand/reduce slice
// Assumes: 32-bit operands, 32-bit instruction words
// Notes:   opcode fields and minor codes live here; the bench model writes its own copies
package prec_pkg;
	// ------------------------------------------------------------
	// instruction fields
	// ------------------------------------------------------------
	localparam logic [5:0] MAJOR_GROUP      = 6'h08;
	localparam int         MAJOR_MSB        = 31;
	localparam int         MAJOR_LSB        = 26;
	localparam int         SA_MSB           = 15;
	localparam int         SA_LSB           = 11;
	localparam int         RND_BIT          = 10;
	localparam logic [2:0] EXP_F86          = 3'h4;
	localparam logic [2:0] EXP_F53          = 3'h7;
	localparam logic [2:0] EXP_F20          = 3'h7;
	localparam logic [2:0] RED_F20          = 3'h5;
	localparam logic [6:0] MIN_EXP_LP       = 7'h58;
	localparam logic [6:0] MIN_EXP_LA       = 7'h59;
	localparam logic [6:0] MIN_EXP_RP       = 7'h68;
	localparam logic [6:0] MIN_EXP_RA       = 7'h69;
	localparam logic [6:0] MIN_RED_HB       = 7'h0D;
	localparam logic [6:0] MIN_SHR          = 7'h79;
	localparam logic [7:0] ZERO_BYTE        = 8'h00;
	localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

	// ------------------------------------------------------------
	// operation codes and carriers
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		op_none,
		op_expand_u8_left_pair,
		op_expand_u8_left_alternate,
		op_expand_u8_right_pair,
		op_expand_u8_right_alternate,
		op_reduce_halfwords_to_bytes,
		op_shift_reduce_words,
		op_shift_round_reduce_words
	} prec_op_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] instr;
		logic [31:0] operand_a;
		logic [31:0] operand_b;
	} prec_req_t;

	typedef struct packed {
		logic        write_en;
		logic        dest_is_b;
		logic        exception;
		logic [31:0] result;
	} prec_rsp_t;
endpackage

// ===== testbench/issue_model.sv
// Purpose: decoder-side model, builds the instruction word for one operation
// Assumes: op_none stands for a word that no listed operation matches
// Notes:   register fields are fixed filler; codes are written out, not shared
`timescale 1ns/10ps
module issue_model (
	// operation choice
	input  wire prec_pkg::prec_op_t op,
	input  wire logic [4:0]         shift_count,
	// encoded word
	output logic [31:0]             instr
);
	// ------------------------------------------------------------
	// encoding
	// ------------------------------------------------------------
	// group on top, filler register fields, then the operation tail
	always_comb begin
		instr = {6'h08, 10'h0A3, 16'h0000};
		case (op)
			prec_pkg::op_expand_u8_left_pair:       instr[15:0] = {7'h58, 9'h13F};
			prec_pkg::op_expand_u8_left_alternate:  instr[15:0] = {7'h59, 9'h13F};
			prec_pkg::op_expand_u8_right_pair:      instr[15:0] = {7'h68, 9'h13F};
			prec_pkg::op_expand_u8_right_alternate: instr[15:0] = {7'h69, 9'h13F};
			prec_pkg::op_reduce_halfwords_to_bytes: instr[15:0] = {5'h03, 1'h0, 7'h0D, 3'h5};
			prec_pkg::op_shift_reduce_words:        instr[15:0] = {shift_count, 1'h0, 7'h79, 3'h5};
			prec_pkg::op_shift_round_reduce_words:  instr[15:0] = {shift_count, 1'h1, 7'h79, 3'h5};
			// unused minor with the wrong tail, so nothing may match
			default:                                instr[15:0] = {7'h7F, 9'h1F8};
		endcase
	end
endmodule

// ===== testbench/tb_simd_precision_expand_reduce.sv
// Purpose: self-checking bench for the expand/reduce slice
// Assumes: one-cycle answer, inputs driven on the falling edge
// Notes:   every request is checked at the falling edge after it is taken
`timescale 1ns/10ps
module tb_simd_precision_expand_reduce;
	logic                 core_clk;
	logic                 rst_n;
	logic                 valid;
	logic                 dsp_access_ok;
	logic [31:0]          op_a;
	logic [31:0]          op_b;
	logic [4:0]           shift_count;
	logic [31:0]          instr_w;
	logic                 sat_flag_we;
	logic                 pend;
	logic                 e_we;
	logic                 e_exc;
	logic                 e_dest;
	logic [31:0]          e_res;
	int                   error_cnt;
	int                   checks;
	int                   cyc;
	prec_pkg::prec_op_t   op;
	prec_pkg::prec_req_t  req;
	prec_pkg::prec_rsp_t  rsp;
	// ------------------------------------------------------------
	// harness
	// ------------------------------------------------------------
	assign req = '{valid, instr_w, op_a, op_b};
	issue_model i_issue (.op(op), .shift_count(shift_count), .instr(instr_w));
	simd_precision_expand_reduce i_dut (.core_clk(core_clk), .rst_n(rst_n), .req(req),
		.dsp_access_ok(dsp_access_ok), .rsp(rsp), .sat_flag_we(sat_flag_we));
	always #25 core_clk = ~core_clk;
	// hang guard, far above the roughly 160 cycles the run needs
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			error_cnt++;
			test_done();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask
	// judges the answer to the request taken at the last rising edge
	task automatic verify();
		if (pend) begin
			chk({31'h0, rsp.write_en}, {31'h0, e_we}, "write_en");
			chk({31'h0, rsp.exception}, {31'h0, e_exc}, "exception");
			chk(rsp.result, e_res, "result");
			if (e_we)
				chk({31'h0, rsp.dest_is_b}, {31'h0, e_dest}, "dest");
		end
		chk({31'h0, sat_flag_we}, 32'h0, "flag write");
	endtask
	task automatic send(input prec_pkg::prec_op_t o, input logic [4:0] s, input logic [31:0] a, input logic [31:0] b,
		input logic ok, input logic we, input logic exc, input logic dest, input logic [31:0] res);
		@(negedge core_clk);
		verify();
		op = o;
		{shift_count, op_a, op_b, dsp_access_ok, valid} = {s, a, b, ok, 1'h1};
		{pend, e_we, e_exc, e_dest, e_res} = {1'h1, we, exc, dest, res};
	endtask
	task automatic idle();
		@(negedge core_clk);
		verify();
		valid = 1'h0;
		{pend, e_we, e_exc, e_res} = {1'h1, 1'h0, 1'h0, 32'h0};
	endtask
	function automatic logic [15:0] exp_sr(input logic [31:0] x, input logic [4:0] s, input logic r);
		logic signed [32:0] xs;
		logic [32:0]        t;
		xs = {x[31], x};
		if (r && s != 5'h00) begin
			t = xs >>> (s - 5'h01);
			t = t + 33'h1;
			return t[16:1];
		end
		t = xs >>> s;
		return t[15:0];
	endfunction
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_expand();
		logic [31:0] a;
		for (int i = 0; i < 2; i++) begin
			a = i ? 32'h80FF017F : 32'hAABBCCDD;
			send(prec_pkg::op_expand_u8_left_pair, 5'h00, a, 32'h0, 1'h1, 1'h1, 1'h0, 1'h1,
				{8'h0, a[31:24], 8'h0, a[23:16]});
			send(prec_pkg::op_expand_u8_left_alternate, 5'h00, a, 32'h0, 1'h1, 1'h1, 1'h0, 1'h1,
				{8'h0, a[31:24], 8'h0, a[15:8]});
			send(prec_pkg::op_expand_u8_right_pair, 5'h00, a, 32'h0, 1'h1, 1'h1, 1'h0, 1'h1,
				{8'h0, a[15:8], 8'h0, a[7:0]});
			send(prec_pkg::op_expand_u8_right_alternate, 5'h00, a, 32'h0, 1'h1, 1'h1, 1'h0, 1'h1,
				{8'h0, a[23:16], 8'h0, a[7:0]});
		end
		idle();
		$display("expand test done");
	endtask
	task automatic t_reduce();
		send(prec_pkg::op_reduce_halfwords_to_bytes, 5'h00, 32'h1234ABCD, 32'hFE5677EF,
			1'h1, 1'h1, 1'h0, 1'h0, 32'h34CD56EF);
		send(prec_pkg::op_reduce_halfwords_to_bytes, 5'h00, 32'hFF00FF00, 32'h00FF00FF,
			1'h1, 1'h1, 1'h0, 1'h0, 32'h0000FFFF);
		idle();
		$display("reduce test done");
	endtask
	// every shift count in both variants, each with both operand sets
	task automatic t_shift();
		logic [31:0] a;
		logic [31:0] b;
		for (int i = 0; i < 128; i++) begin
			a = i[6] ? 32'h0001FFFF : 32'h87654321;
			b = i[6] ? 32'hFFFFFFFF : 32'h7FFFC001;
			send(i[5] ? prec_pkg::op_shift_round_reduce_words : prec_pkg::op_shift_reduce_words,
				i[4:0], a, b, 1'h1, 1'h1, 1'h0, 1'h1,
				{exp_sr(b, i[4:0], i[5]), exp_sr(a, i[4:0], i[5])});
		end
		idle();
		$display("shift test done");
	endtask
	task automatic t_refuse();
		send(prec_pkg::op_expand_u8_left_pair, 5'h00, 32'hFFFFFFFF, 32'h0, 1'h0, 1'h0, 1'h1, 1'h0, 32'h0);
		send(prec_pkg::op_shift_round_reduce_words, 5'h04, 32'h80000000, 32'h0, 1'h0, 1'h0, 1'h1, 1'h0, 32'h0);
		send(prec_pkg::op_shift_reduce_words, 5'h1F, 32'h80000000, 32'h7FFFFFFF, 1'h1, 1'h1, 1'h0, 1'h1, 32'h0000FFFF);
		send(prec_pkg::op_none, 5'h00, 32'h12345678, 32'h0, 1'h1, 1'h0, 1'h0, 1'h0, 32'h0);
		idle();
		$display("refusal test done");
	endtask
	// ------------------------------------------------------------
	// closing and main sequence
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{core_clk, rst_n, valid, dsp_access_ok, pend} = 5'h01;
		{op_a, op_b, shift_count, error_cnt, checks, cyc} = '0;
		{e_we, e_exc, e_dest, e_res} = '0;
		op = prec_pkg::op_none;
		repeat (10) @(negedge core_clk);
		chk({29'h0, rsp.write_en, rsp.dest_is_b, rsp.exception}, 32'h0, "reset flags");
		chk(rsp.result, 32'h0, "reset result");
		rst_n = 1'h1;
		t_expand();
		t_reduce();
		t_shift();
		t_refuse();
		idle();
		test_done();
	end
endmodule
